// ===== include/sink_bank_pkg.sv
// Constants and types shared by the sink driver register bank and its serial engine
package sink_bank_pkg;
    localparam int CLK_KHZ = 20000;
    localparam int TIMEOUT_MS = 90;
    localparam int TIMEOUT_MAX_MS = 150;
    localparam int TIMEOUT_CYCLES = TIMEOUT_MS * CLK_KHZ;
    localparam logic [6:0] DEV_ADDR = 7'h70;
    localparam int NUM_REGS = 5;
    localparam int NUM_CH = 4;
    localparam int CODE_W = 6;
    localparam int CFG_W = 6;
    localparam int STEP_UA = 500;
    localparam logic [2:0] IDX_CTRL = 3'h0;
    localparam logic [2:0] IDX_LAST = 3'h4;
    localparam logic [2:0] IDX_PAST = 3'h5;
    localparam int PS_HI = 7;
    localparam int PS_LO = 6;
    localparam int EN_HI = 5;
    localparam int EN_LO = 2;
    localparam int OVT_BIT = 1;
    localparam int UV_BIT = 0;
    localparam int CODE_HI = 7;
    localparam int CODE_LO = 2;
    localparam logic [1:0] PS_CLEAR = 2'h0;
    localparam logic [1:0] PS_OFF_KEEP = 2'h1;
    localparam logic [1:0] PS_STANDBY = 2'h2;
    localparam logic [1:0] PS_ACTIVE = 2'h3;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] READ_PAST = 8'h00;
    localparam int SNAP_W = CFG_W + NUM_CH * CODE_W;
    typedef logic [CODE_W-1:0] code_t;
    typedef logic [1:0] pstate_t;
    typedef logic [CFG_W-1:0] cfg_t;
endpackage

// ===== include/bank_link_if.sv
// Link-domain signals between the serial engine and the register bank
`timescale 1ns/1ns
interface bank_link_if;
    logic link_rst;
    logic wr_stb;
    logic [2:0] wr_idx;
    logic [7:0] wr_data;
    logic [2:0] rd_idx;
    logic [7:0] rd_data;
    modport engine (
        input link_rst,
        input rd_data,
        output wr_stb,
        output wr_idx,
        output wr_data,
        output rd_idx
    );
    modport bank (
        output link_rst,
        output rd_data,
        input wr_stb,
        input wr_idx,
        input wr_data,
        input rd_idx
    );
endinterface

// ===== verilog/serial_engine.sv
// Two-wire serial slave engine running in the link clock domain
`timescale 1ns/1ns
module serial_engine (
    input wire logic bus_clk,
    bank_link_if.engine bus,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_oe_n
);
    import sink_bank_pkg::*;

    typedef enum logic [2:0] {S_IDLE, S_ADDR, S_ACK, S_WRITE, S_READ, S_MACK} eng_state_t;

    typedef struct packed {
        logic scl_m;
        logic scl_s;
        logic scl_d;
        logic sda_m;
        logic sda_s;
        logic sda_d;
        eng_state_t st;
        logic [3:0] bitcnt;
        logic [7:0] sh;
        logic rw;
        logic [2:0] idx;
        logic pull;
        logic wr_stb;
        logic [2:0] wr_idx;
        logic [7:0] wr_data;
    } engine_t;

    engine_t s;
    engine_t next_s;
    logic rise;
    logic fall;
    logic start;
    logic stop;

    assign rise = s.scl_s & ~s.scl_d;
    assign fall = ~s.scl_s & s.scl_d;
    assign start = s.scl_s & s.scl_d & s.sda_d & ~s.sda_s;
    assign stop = s.scl_s & s.scl_d & ~s.sda_d & s.sda_s;

    always_comb begin
        next_s = s;
        next_s.wr_stb = 1'b0;
        next_s.scl_m = scl_in;
        next_s.scl_s = s.scl_m;
        next_s.scl_d = s.scl_s;
        next_s.sda_m = sda_in;
        next_s.sda_s = s.sda_m;
        next_s.sda_d = s.sda_s;
        if (bus.link_rst) begin
            next_s = '0;
        end else if (start) begin
            next_s.st = S_ADDR;
            next_s.bitcnt = 4'h0;
            next_s.idx = IDX_CTRL;
            next_s.pull = 1'b0;
        end else if (stop) begin
            next_s.st = S_IDLE;
            next_s.pull = 1'b0;
        end else begin
            case (s.st)
                S_ADDR: begin
                    if (rise) begin
                        next_s.sh = {s.sh[6:0], s.sda_s};
                        next_s.bitcnt = s.bitcnt + 4'h1;
                        if (s.bitcnt == 4'h7) begin
                            if (s.sh[6:0] == DEV_ADDR) begin
                                next_s.rw = s.sda_s;
                                next_s.st = S_ACK;
                            end else begin
                                next_s.st = S_IDLE;
                            end
                        end
                    end
                end
                S_ACK: begin
                    if (fall) begin
                        if (!s.pull) begin
                            next_s.pull = 1'b1;
                        end else begin
                            next_s.bitcnt = 4'h0;
                            if (s.rw) begin
                                next_s.pull = ~bus.rd_data[7];
                                next_s.sh = {bus.rd_data[6:0], 1'b0};
                                next_s.st = S_READ;
                            end else begin
                                next_s.pull = 1'b0;
                                next_s.st = S_WRITE;
                            end
                        end
                    end
                end
                S_WRITE: begin
                    if (rise) begin
                        next_s.sh = {s.sh[6:0], s.sda_s};
                        next_s.bitcnt = s.bitcnt + 4'h1;
                        if (s.bitcnt == 4'h7) begin
                            next_s.st = S_ACK;
                            if (s.idx != IDX_PAST) begin
                                next_s.wr_stb = 1'b1;
                                next_s.wr_idx = s.idx;
                                next_s.wr_data = {s.sh[6:0], s.sda_s};
                                next_s.idx = s.idx + 3'h1;
                            end
                        end
                    end
                end
                S_READ: begin
                    if (rise) begin
                        next_s.bitcnt = s.bitcnt + 4'h1;
                    end else if (fall) begin
                        if (s.bitcnt == 4'h8) begin
                            next_s.pull = 1'b0;
                            next_s.st = S_MACK;
                        end else begin
                            next_s.pull = ~s.sh[7];
                            next_s.sh = {s.sh[6:0], 1'b0};
                        end
                    end
                end
                S_MACK: begin
                    if (rise) begin
                        // Not-acknowledge ends the read; wait for stop or start
                        if (s.sda_s) begin
                            next_s.st = S_IDLE;
                        end else begin
                            next_s.bitcnt = 4'h9;
                            if (s.idx != IDX_PAST) begin
                                next_s.idx = s.idx + 3'h1;
                            end
                        end
                    end else if (fall && s.bitcnt == 4'h9) begin
                        next_s.bitcnt = 4'h0;
                        next_s.pull = ~bus.rd_data[7];
                        next_s.sh = {bus.rd_data[6:0], 1'b0};
                        next_s.st = S_READ;
                    end
                end
                default: begin
                    next_s.st = S_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge bus_clk) begin
        s <= next_s;
    end

    assign sda_oe_n = ~s.pull;
    assign bus.wr_stb = s.wr_stb;
    assign bus.wr_idx = s.wr_idx;
    assign bus.wr_data = s.wr_data;
    assign bus.rd_idx = s.idx;
endmodule // serial_engine

// ===== verilog/sink_bank_top.sv
// Register bank, bus-low timeout and sink drive levels of the four-channel current-sink driver
`timescale 1ns/1ns
// Summary of operation
// - Five 8-bit registers are reachable: one control register, then four channel registers.
// - Control holds power select in bits 7:6, enables 4..1 in 5:2, overtemp 1, undervolt 0.
// - Power select 00 clears all, 01 off and keeps, 10 standby and keeps, 11 active drive.
// - Each channel enable bit turns its own sink drive in or out independently.
// - Bits 1 and 0 read the live overtemperature and undervoltage conditions, 0 normally.
// - Channel registers carry a six-bit code in bits 7:2, bits 1:0 unused and read zero.
// - The code maps linearly to sink current in half-milliamp steps, 0 to 31.5 mA.
// - A read returns control then channels 1 to 4 in order.
// - Both bus lines low for the timeout clears power select and every register.
// - Shutdown is left only by a write over the serial bus.
// - The bus-low timeout is typically 90 ms and never above 150 ms.
// - The device answers the seven-bit address 0x70.
module sink_bank_top #(
    parameter int TIMEOUT_CYCLES = sink_bank_pkg::TIMEOUT_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic bus_clk,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic overtemp,
    input wire logic undervolt,
    output sink_bank_pkg::pstate_t power_state,
    output logic [sink_bank_pkg::NUM_CH-1:0] sink_active,
    output sink_bank_pkg::code_t sink_ch_one,
    output sink_bank_pkg::code_t sink_ch_two,
    output sink_bank_pkg::code_t sink_ch_three,
    output sink_bank_pkg::code_t sink_ch_four
);
    import sink_bank_pkg::*;

    localparam int TO_W = $clog2(TIMEOUT_CYCLES + 1);

    // Link-domain state: registers, snapshot toward the core, synchronisers
    typedef struct packed {
        logic rst_m;
        logic rst_s;
        logic ovt_m;
        logic ovt_s;
        logic uv_m;
        logic uv_s;
        logic to_m;
        logic to_s;
        logic to_d;
        logic ack_m;
        logic ack_s;
        cfg_t cfg;
        code_t [NUM_CH-1:0] code;
        logic [SNAP_W-1:0] snap;
        logic req;
    } link_state_t;

    // Core-domain state: timeout counter, shadow copy, drive outputs
    typedef struct packed {
        logic scl_m;
        logic scl_s;
        logic sda_m;
        logic sda_s;
        logic [TO_W-1:0] low_cnt;
        logic to_tgl;
        logic req_m;
        logic req_s;
        logic ack;
        logic [SNAP_W-1:0] shadow;
        pstate_t ps;
        logic [NUM_CH-1:0] active;
        code_t [NUM_CH-1:0] level;
    } core_state_t;

    link_state_t l;
    link_state_t next_l;
    core_state_t c;
    core_state_t next_c;

    bank_link_if bus ();

    function automatic pstate_t ps_of(input cfg_t cfg);
        return cfg[PS_HI-EN_LO:PS_LO-EN_LO];
    endfunction

    function automatic logic [NUM_CH-1:0] en_of(input cfg_t cfg);
        return cfg[EN_HI-EN_LO:0];
    endfunction

    function automatic logic [SNAP_W-1:0] pack_snap(
        input cfg_t cfg,
        input code_t [NUM_CH-1:0] code
    );
        return {cfg, code};
    endfunction

    function automatic logic [7:0] reg_read(
        input logic [2:0] idx,
        input cfg_t cfg,
        input logic overtemp_flag,
        input logic uv,
        input code_t [NUM_CH-1:0] code
    );
        logic [7:0] r;
        r = READ_PAST;
        if (idx == IDX_CTRL) begin
            r = {cfg, overtemp_flag, uv};
        end else if (idx <= IDX_LAST) begin
            r = {code[2'(idx - 3'h1)], 2'h0};
        end
        return r;
    endfunction

    // Link domain
    always_comb begin
        next_l = l;
        next_l.rst_m = rst;
        next_l.rst_s = l.rst_m;
        next_l.ovt_m = overtemp;
        next_l.ovt_s = l.ovt_m;
        next_l.uv_m = undervolt;
        next_l.uv_s = l.uv_m;
        next_l.to_m = c.to_tgl;
        next_l.to_s = l.to_m;
        next_l.to_d = l.to_s;
        next_l.ack_m = c.ack;
        next_l.ack_s = l.ack_m;
        if (l.rst_s) begin
            next_l.cfg = REG_RESET[PS_HI:EN_LO];
            next_l.code = '0;
            next_l.snap = '0;
            next_l.req = 1'b0;
            next_l.to_d = 1'b0;
            next_l.to_s = 1'b0;
        end else begin
            if (l.to_s != l.to_d) begin
                // Timeout wins over a write landing in the same cycle
                next_l.cfg = '0;
                next_l.code = '0;
            end else if (bus.wr_stb) begin
                if (bus.wr_idx == IDX_CTRL) begin
                    if (bus.wr_data[PS_HI:PS_LO] == PS_CLEAR) begin
                        next_l.cfg = '0;
                        next_l.code = '0;
                    end else begin
                        // Flag bits are live readback and never stored
                        next_l.cfg = bus.wr_data[PS_HI:EN_LO];
                    end
                end else if (ps_of(l.cfg) != PS_CLEAR) begin
                    // Channels stay cleared while power select holds 00
                    next_l.code[2'(bus.wr_idx - 3'h1)] = bus.wr_data[CODE_HI:CODE_LO];
                end
            end
            // Handshake idle and copy stale: hand a fresh snapshot across
            if (l.ack_s == l.req && l.snap != pack_snap(l.cfg, l.code)) begin
                next_l.snap = pack_snap(l.cfg, l.code);
                next_l.req = ~l.req;
            end
        end
    end

    always_ff @(posedge bus_clk) begin
        l <= next_l;
    end

    assign bus.link_rst = l.rst_s;
    assign bus.rd_data = reg_read(bus.rd_idx, l.cfg, l.ovt_s, l.uv_s, l.code);

    serial_engine engine (
        .bus_clk(bus_clk),
        .bus(bus.engine),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_oe_n(sda_oe_n)
    );

    // Core domain
    always_comb begin
        next_c = c;
        next_c.scl_m = scl_in;
        next_c.scl_s = c.scl_m;
        next_c.sda_m = sda_in;
        next_c.sda_s = c.sda_m;
        next_c.req_m = l.req;
        next_c.req_s = c.req_m;
        if (rst) begin
            next_c = '0;
        end else begin
            // Both lines low: count toward a forced shutdown, firing once
            if (c.scl_s || c.sda_s) begin
                next_c.low_cnt = '0;
            end else if (c.low_cnt != TO_W'(TIMEOUT_CYCLES - 1)) begin
                next_c.low_cnt = c.low_cnt + TO_W'(1);
                if (c.low_cnt == TO_W'(TIMEOUT_CYCLES - 2)) begin
                    next_c.to_tgl = ~c.to_tgl;
                end
            end
            // Snapshot is held steady by the link side until acknowledged
            if (c.req_s != c.ack) begin
                next_c.shadow = l.snap;
                next_c.ack = c.req_s;
            end
            next_c.ps = ps_of(c.shadow[SNAP_W-1 -: CFG_W]);
            next_c.active = (next_c.ps == PS_ACTIVE)
                ? en_of(c.shadow[SNAP_W-1 -: CFG_W]) : '0;
            for (int i = 0; i < NUM_CH; i++) begin
                next_c.level[i] = next_c.active[i]
                    ? c.shadow[i*CODE_W +: CODE_W] : '0;
            end
        end
    end

    always_ff @(posedge clk) begin
        c <= next_c;
    end

    // Open-drain line: only ever pulled low
    assign sda_out = 1'b0;
    assign power_state = c.ps;
    assign sink_active = c.active;
    // Sink current equals level times STEP_UA
    assign sink_ch_one = c.level[0];
    assign sink_ch_two = c.level[1];
    assign sink_ch_three = c.level[2];
    assign sink_ch_four = c.level[3];
endmodule // sink_bank_top

// ===== sim/sink_bank_properties.sv
// Port assertions for the sink driver register bank
`timescale 1ns/1ns
module sink_bank_properties #(
    parameter int TIMEOUT_CYCLES = 50
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic bus_clk,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire sink_bank_pkg::pstate_t power_state,
    input wire logic [sink_bank_pkg::NUM_CH-1:0] sink_active,
    input wire sink_bank_pkg::code_t sink_ch_one,
    input wire sink_bank_pkg::code_t sink_ch_two,
    input wire sink_bank_pkg::code_t sink_ch_three,
    input wire sink_bank_pkg::code_t sink_ch_four
);
    import sink_bank_pkg::*;
    // Writes land well inside this many idle cycles after the last pin edge
    localparam int QUIET_MAX = 40;
    logic scl_q;
    logic sda_q;
    logic [15:0] quiet;
    logic [15:0] low_cnt;
    always_ff @(posedge clk) begin
        scl_q <= scl_in;
        sda_q <= sda_in;
        if (rst || scl_in != scl_q || sda_in != sda_q) begin
            quiet <= 16'h0000;
        end else if (quiet != 16'hffff) begin
            quiet <= quiet + 16'h0001;
        end
        if (rst || scl_in || sda_in) begin
            low_cnt <= 16'h0000;
        end else if (low_cnt != 16'hffff) begin
            low_cnt <= low_cnt + 16'h0001;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence ack_hold;
        !sda_oe_n [*4];
    endsequence
    sequence stay_off;
        (power_state != PS_ACTIVE) [*3];
    endsequence
    chk_sink_gated: assert property (
        (sink_active != 4'h0) [*3] |-> power_state == PS_ACTIVE)
        else $error("Sink drawing outside active state");
    chk_levels_off: assert property (
        stay_off |-> sink_active == 4'h0 &&
        {sink_ch_one, sink_ch_two, sink_ch_three, sink_ch_four} == 24'h0)
        else $error("Drive level while not active");
    chk_data_open: assert property (sda_out == 1'b0)
        else $error("Data pin value not low");
    chk_no_wake: assert property (
        $changed(power_state) && power_state != PS_CLEAR |-> quiet < QUIET_MAX)
        else $error("Power state moved without bus traffic");
    chk_level_source: assert property (
        $changed({sink_active, sink_ch_one, sink_ch_two, sink_ch_three, sink_ch_four})
        && power_state == PS_ACTIVE && low_cnt == 16'h0000 |-> quiet < QUIET_MAX)
        else $error("Drive changed without bus traffic");
    chk_timeout_clear: assert property (
        int'(low_cnt) == TIMEOUT_CYCLES + 40 |-> power_state == PS_CLEAR && sink_active == 4'h0)
        else $error("Bus low timeout did not shut down");
    chk_ack_holds: assert property (
        @(posedge bus_clk) disable iff (rst) $fell(sda_oe_n) |-> ack_hold)
        else $error("Data drive too short");
    chk_drive_scl_low: assert property (
        @(posedge bus_clk) disable iff (rst) $changed(sda_oe_n) |-> !scl_in)
        else $error("Data drive changed while clock high");
endmodule // sink_bank_properties
bind sink_bank_top sink_bank_properties #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) i_sink_bank_properties (
    .clk(clk), .rst(rst), .bus_clk(bus_clk), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .power_state(power_state),
    .sink_active(sink_active), .sink_ch_one(sink_ch_one), .sink_ch_two(sink_ch_two),
    .sink_ch_three(sink_ch_three), .sink_ch_four(sink_ch_four));

// ===== sim/i2c_master_model.sv
// Two-wire bus master model driving the bank's clock and data lines
`timescale 1ns/1ns
module i2c_master_model (
    input wire logic bus_clk,
    input wire logic sda_in,
    output logic scl,
    output logic sda_drv
);
    logic [31:0] res;
    event res_ev;
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge bus_clk);
    endtask
    task automatic start();
        sda_drv = 1'b1;
        tick(6);
        scl = 1'b1;
        tick(6);
        sda_drv = 1'b0;
        tick(6);
        scl = 1'b0;
        tick(2);
    endtask
    task automatic stop();
        sda_drv = 1'b0;
        tick(6);
        scl = 1'b1;
        tick(6);
        sda_drv = 1'b1;
        tick(6);
    endtask
    // Data moves only in the low phase; both phases exceed four link cycles
    task automatic clk_bit(input logic b, output logic s);
        sda_drv = b;
        tick(4);
        scl = 1'b1;
        tick(3);
        s = sda_in;
        tick(3);
        scl = 1'b0;
        tick(2);
    endtask
    task automatic write_byte(input logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
        clk_bit(1'b1, s);
        res = {31'h0, !s};
        -> res_ev;
    endtask
    task automatic read_byte(input logic last);
        logic s;
        logic [7:0] v;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, s);
            v[i] = s;
        end
        clk_bit(last, s);
        res = {24'h0, v};
        -> res_ev;
    endtask
    // Both lines held low on purpose, for the shutdown timeout
    task automatic hold_low(input int n);
        sda_drv = 1'b0;
        tick(6);
        scl = 1'b0;
        tick(n);
        scl = 1'b1;
        tick(6);
        sda_drv = 1'b1;
        tick(6);
    endtask
endmodule // i2c_master_model

// ===== sim/led_sink_i2c_register_bank_test.sv
// Self-checking bench for the sink driver register bank
`timescale 1ns/1ns
module led_sink_i2c_register_bank_test;
    import sink_bank_pkg::*;
    typedef struct {string what; logic [31:0] val;} note_t;
    localparam int TMO = 50;
    logic clk = 1'b0;
    logic bus_clk = 1'b0;
    logic rst = 1'b1;
    logic overtemp = 1'b0;
    logic undervolt = 1'b0;
    logic scl, sda_drv, sda_out, sda_oe_n;
    wire logic sda_w;
    pstate_t power_state, ps;
    logic [NUM_CH-1:0] sink_active, en;
    code_t sink_ch_one, sink_ch_two, sink_ch_three, sink_ch_four;
    code_t code [4];
    note_t exp_q[$];
    logic [31:0] port_val;
    event port_ev;
    int fails = 0;
    int tests_run = 0;
    int seed = 64681;
    // Open drain wire with pull-up
    assign sda_w = sda_drv & sda_oe_n;
    always #25 clk = ~clk;
    initial begin
        #7;
        forever #24 bus_clk = ~bus_clk;
    end
    sink_bank_top #(.TIMEOUT_CYCLES(TMO)) i_sink_bank_top (.clk(clk), .rst(rst),
        .bus_clk(bus_clk), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .overtemp(overtemp), .undervolt(undervolt),
        .power_state(power_state), .sink_active(sink_active), .sink_ch_one(sink_ch_one),
        .sink_ch_two(sink_ch_two), .sink_ch_three(sink_ch_three), .sink_ch_four(sink_ch_four));
    i2c_master_model i_i2c_master_model (.bus_clk(bus_clk), .sda_in(sda_w), .scl(scl),
        .sda_drv(sda_drv));
    task automatic note(input string what, input logic [31:0] val);
        exp_q.push_back('{what, val});
    endtask
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] expected);
        tests_run++;
        if (seen !== expected) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, expected, seen);
        end
    endtask
    // Oldest note pairs with the result that has just appeared
    task automatic take(input logic [31:0] seen);
        note_t n;
        n = '{"unexpected", 32'hx};
        if (exp_q.size() > 0) n = exp_q.pop_front();
        check(n.what, seen, n.val);
    endtask
    always @(i_i2c_master_model.res_ev) take(i_i2c_master_model.res);
    always @(port_ev) take(port_val);
    function automatic logic [31:0] pred();
        logic [31:0] v = {2'b00, ps, 28'h0};
        if (ps == PS_ACTIVE) begin
            v[27:24] = en;
            for (int i = 0; i < 4; i++) if (en[i]) v[23-6*i -: 6] = code[i];
        end
        return v;
    endfunction
    task automatic snap(input string what);
        repeat (30) @(negedge clk);
        note(what, pred());
        port_val = {2'b00, power_state, sink_active, sink_ch_one, sink_ch_two,
            sink_ch_three, sink_ch_four};
        -> port_ev;
        @(negedge clk);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d[$]);
        i_i2c_master_model.start();
        note("address ack", {31'h0, a == DEV_ADDR});
        i_i2c_master_model.write_byte({a, 1'b0});
        if (a == DEV_ADDR) foreach (d[i]) begin
            note("data ack", 32'h1);
            i_i2c_master_model.write_byte(d[i]);
        end
        i_i2c_master_model.stop();
    endtask
    task automatic rd_all();
        logic [7:0] e[$];
        e = '{{ps, en, overtemp, undervolt}, {code[0], 2'b00}, {code[1], 2'b00},
            {code[2], 2'b00}, {code[3], 2'b00}, 8'h00};
        i_i2c_master_model.start();
        note("address ack", 32'h1);
        i_i2c_master_model.write_byte({DEV_ADDR, 1'b1});
        foreach (e[i]) begin
            note("read byte", {24'h0, e[i]});
            i_i2c_master_model.read_byte(i == 5);
        end
        i_i2c_master_model.stop();
        @(negedge clk);
    endtask
    task automatic full_write();
        foreach (code[i]) code[i] = code_t'($random(seed));
        wr(DEV_ADDR, '{{ps, en, 2'b11}, {code[0], 2'b01}, {code[1], 2'b10},
            {code[2], 2'b11}, {code[3], 2'b01}, 8'h5a});
    endtask
    task automatic cleared();
        ps = PS_CLEAR;
        en = 4'h0;
        foreach (code[i]) code[i] = 6'h00;
    endtask
    task automatic conclude();
        fails += exp_q.size();
        $display("Comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        #2000000;
        fails++;
        conclude();
    end
    initial begin
        repeat (16) @(negedge clk);
        rst = 1'b0;
        repeat (20) @(negedge clk);
        cleared();
        snap("reset levels");
        $display("Test reset done");
        ps = PS_ACTIVE;
        en = 4'b1011;
        full_write();
        snap("full write");
        overtemp = 1'b1;
        rd_all();
        $display("Test full write done");
        overtemp = 1'b0;
        undervolt = 1'b1;
        ps = PS_STANDBY;
        en = 4'b1111;
        wr(DEV_ADDR, '{{ps, en, 2'b00}});
        snap("standby");
        rd_all();
        undervolt = 1'b0;
        ps = PS_OFF_KEEP;
        wr(DEV_ADDR, '{{ps, en, 2'b00}});
        snap("off keep");
        ps = PS_ACTIVE;
        for (int i = 0; i < 4; i++) begin
            en = 4'h1 << i;
            wr(DEV_ADDR, '{{ps, en, 2'b00}});
            snap("one channel");
        end
        $display("Test retention done");
        wr(7'h71, '{8'h00});
        snap("foreign address");
        wr(DEV_ADDR, '{8'h00, 8'hfc, 8'hfc, 8'hfc, 8'hfc});
        cleared();
        snap("clear write");
        rd_all();
        $display("Test clear done");
        ps = PS_ACTIVE;
        en = 4'b1111;
        full_write();
        snap("before timeout");
        // Channels 1 and 2 tied together share one code; 3 and 4 not reached
        code[1] = code[0];
        wr(DEV_ADDR, '{{ps, en, 2'b00}, {code[0], 2'b00}, {code[1], 2'b00}});
        snap("paralleled pair");
        i_i2c_master_model.hold_low(150);
        cleared();
        repeat (300) @(negedge clk);
        snap("bus timeout");
        rd_all();
        $display("Test timeout done");
        conclude();
    end
endmodule // led_sink_i2c_register_bank_test
